//--- pkg/cpg_pkg.sv
// Constants, types and decode functions for the charge pump gain sequencer
package cpg_pkg;

  // Register offsets on the plain register port
  localparam logic [2:0] ADDR_MODE_CTRL   = 3'h0;
  localparam logic [2:0] ADDR_OUT_LIMIT   = 3'h1;
  localparam logic [2:0] ADDR_TORCH_CUR   = 3'h2;
  localparam logic [2:0] ADDR_FLASH_CUR   = 3'h3;
  localparam logic [2:0] ADDR_STATUS      = 3'h4;

  // Reset values
  localparam logic [7:0] MODE_CTRL_RST    = 8'h00;
  localparam logic [7:0] OUT_LIMIT_RST    = 8'h00;
  localparam logic [7:0] TORCH_CUR_RST    = 8'h00;
  localparam logic [7:0] FLASH_CUR_RST    = 8'h00;

  // Field positions
  localparam int MODE_HI_BIT   = 7;
  localparam int MODE_LO_BIT   = 6;
  localparam int GSEL_HI_BIT   = 4;
  localparam int GSEL_LO_BIT   = 3;
  localparam int CHEN_HI_BIT   = 7;
  localparam int CHEN_LO_BIT   = 5;
  localparam int CEIL_HI_BIT   = 7;
  localparam int CEIL_LO_BIT   = 5;

  // Mode patterns of bits 7,6 with gain select 00
  localparam logic [1:0] MODE_HET         = 2'h1;
  localparam logic [1:0] MODE_AUTO_TORCH  = 2'h2;
  localparam logic [1:0] MODE_AUTO_FLASH  = 2'h3;
  localparam logic [1:0] GSEL_AUTO        = 2'h0;

  // Fixed ceiling code used for torch and high-efficiency torch (4.5 V)
  localparam logic [2:0] CEIL_CODE_4V5    = 3'h2;

  // Comparator flag vector layout
  localparam int NUM_CH       = 3;
  localparam int NUM_FLAGS    = 16;
  localparam int F_CEIL       = 0;
  localparam int F_HYST_LOW   = 1;
  localparam int F_GT_VIN     = 2;
  localparam int F_LT_VIN_M1  = 3;
  localparam int F_IIN_LE400  = 4;
  localparam int F_IIN_LT300  = 5;
  localparam int F_OUT_SHORT  = 6;
  localparam int F_TEMP_HOT   = 7;
  localparam int F_TEMP_COOL  = 8;
  localparam int F_VOUT_OPEN  = 9;
  localparam int F_DROP_LO    = 10;
  localparam int F_SHORT_LO   = 13;

  // Dropout wait: 64 pump cycles at 2.4 MHz, on a 100 MHz clock
  localparam longint CLK_HZ        = 100_000_000;
  localparam longint PUMP_CLK_HZ   = 2_400_000;
  localparam longint PUMP_CYCLES   = 64;
  localparam longint DROPOUT_CLKS  =
    (PUMP_CYCLES * CLK_HZ + PUMP_CLK_HZ - 1) / PUMP_CLK_HZ;
  localparam int DTO_W = 12;
  localparam logic [DTO_W-1:0] DTO_LOAD = DTO_W'(DROPOUT_CLKS - 1);

  // Pump gain codes
  typedef enum logic [1:0] {
    GAIN_OFF = 2'h0,
    GAIN_1X  = 2'h1,
    GAIN_15X = 2'h2,
    GAIN_2X  = 2'h3
  } cpg_gain_t;

  // Start-up voltage algorithm: limits a wanted gain by VOUT versus VIN
  function automatic cpg_gain_t cpg_clamp_gain(input cpg_gain_t g,
                                               input logic lt_vin_m1,
                                               input logic gt_vin);
    cpg_gain_t r;
    r = g;
    if (g != GAIN_OFF) begin
      if (lt_vin_m1)
        r = GAIN_1X;
      else if (!gt_vin && g == GAIN_2X)
        r = GAIN_15X;
      else if (gt_vin && g == GAIN_1X)
        r = GAIN_15X;
    end
    return r;
  endfunction

  // Next higher gain, saturating at 2x
  function automatic cpg_gain_t cpg_step_up(input cpg_gain_t g);
    cpg_gain_t r;
    r = (g == GAIN_2X) ? GAIN_2X : cpg_gain_t'(g + 2'h1);
    return r;
  endfunction

endpackage

//--- pkg/cpg_dto_if.sv
// Dropout timer handshake between the sequencer and its timer
`timescale 1ns/1ps
interface cpg_dto_if;
  logic start;
  logic clear;
  logic expired;

  modport ctl (output start, output clear, input expired);
  modport tmr (input start, input clear, output expired);
endinterface

//--- rtl/cpg_dropout_timer.sv
// Dropout wait timer: pulses expired a fixed time after start
`timescale 1ns/1ps
module cpg_dropout_timer (
  // Clock and control
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  // Sequencer side
  cpg_dto_if.tmr    dto
);

  logic [cpg_pkg::DTO_W-1:0] cnt_r;
  logic                      run_r;
  logic                      exp_r;

  // Count down; clear wins over start so a disable never leaves it armed
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      exp_r <= 1'b0;
    end else if (ce) begin
      exp_r <= 1'b0;
      if (dto.clear) begin
        cnt_r <= '0;
        run_r <= 1'b0;
      end else if (dto.start) begin
        cnt_r <= cpg_pkg::DTO_LOAD;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r == '0) begin
          exp_r <= 1'b1;
          run_r <= 1'b0;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end

  assign dto.expired = exp_r;

endmodule

//--- rtl/cpg_top.sv
// Charge pump gain sequencer with mode registers and protection
`timescale 1ns/1ps
// Overview of operation
// - Mode bits 7,6,4,3 = 1000 auto torch start, 1100 auto flash start
// - Pattern 0100 selects high-efficiency torch; torch enables pick channels
// - Entering auto start switches off all programmed LED channels first
// - In auto start, reaching ceiling stops pump and releases LED control
// - Auto start steps 1x/1.5x/2x keeping battery current high, under 600mA
// - Auto start begins at 1x, or 1.5x when output exceeds input
// - Step 1x to 1.5x once input current falls to about 400mA
// - Step 1.5x to 2x below ceiling with current under 300mA; stay till ceiling
// - Ceiling never reached: keep pumping at 2x with no own timeout
// - Programmed gain is a request; start-up algorithm still overrides it, up or down
// - Forced 1.5x with raised ceiling after charge restarts pump at 1.5x
// - High-efficiency torch charges to ceiling, then regulates on channel dropout
// - Dropout threshold 220mV at 1x, 180mV at 1.5x or 2x
// - High-efficiency torch starts pump on channel dropout below ceiling
// - Still in dropout 64 pump cycles after start: step gain up
// - High-efficiency torch stops pump at once on reaching ceiling
// - Output short forces 1x with 600mA current limit in any start mode
// - Disable above 150C flag, re-enable only at below 140C flag
// - Channel with output-to-pin under 200mV has only its driver switched off
// - Open output sense pin disconnects output from input
// - Start-up: 1x only far below input, no 2x near, no 1x above
// - Torch or flash restart after ceiling after 50mV hysteresis drop or an output limit write
// - Ceiling 4.5V in torch modes, programmed ceiling code in flash
// - Channel enables 000 in either current register enter standby
module cpg_top (
  // Clock, reset and enables
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        enable_n,
  // Register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Analog comparator flags
  input  wire logic        ceil_reached,
  input  wire logic        ceil_hyst_low,
  input  wire logic        vout_gt_vin,
  input  wire logic        vout_lt_vin_m1,
  input  wire logic        iin_le_400ma,
  input  wire logic        iin_lt_300ma,
  input  wire logic        out_short,
  input  wire logic        temp_hot,
  input  wire logic        temp_cool,
  input  wire logic        vout_open,
  input  wire logic [2:0]  chan_dropout,
  input  wire logic [2:0]  chan_short,
  // Power stage controls
  output logic             pump_on,
  output logic      [1:0]  pump_gain,
  output logic             dropout_sel_180,
  output logic      [2:0]  ceiling_code,
  output logic             ilim_600,
  output logic             out_disconnect,
  output logic             standby,
  output logic             therm_off,
  // LED driver controls
  output logic      [2:0]  chan_drv_en,
  output logic      [3:0]  torch_dac,
  output logic      [2:0]  flash_dac,
  output logic             flash_sel
);

  typedef enum logic [6:0] {
    ST_OFF      = 7'h01,
    ST_AUTO     = 7'h02,
    ST_PROG     = 7'h04,
    ST_HOLD     = 7'h08,
    ST_HET_CHG  = 7'h10,
    ST_HET_IDLE = 7'h20,
    ST_HET_PUMP = 7'h40
  } cpg_state_t;

  logic [7:0]                  mode_control_reg;
  logic [7:0]                  output_limit_reg;
  logic [7:0]                  torch_current_reg;
  logic [7:0]                  flash_current_reg;
  logic [cpg_pkg::NUM_FLAGS-1:0] flag_meta_r;
  logic [cpg_pkg::NUM_FLAGS-1:0] flag_r;
  logic [cpg_pkg::NUM_FLAGS-1:0] flag_raw;
  cpg_state_t                  state_r;
  cpg_state_t                  state_nxt;
  cpg_pkg::cpg_gain_t          gain_r;
  cpg_pkg::cpg_gain_t          gain_want;
  cpg_pkg::cpg_gain_t          gain_nxt;
  logic                        release_r;
  logic                        release_nxt;
  logic                        therm_off_r;
  logic                        standby_r;
  logic [7:0]                  rdata_r;
  logic [2:0]                  drv_en_r;
  logic                        mode_wr;
  logic                        limit_wr;
  logic                        active;
  logic                        is_het;
  logic                        is_auto;
  logic                        is_flash;
  logic [1:0]                  mode_sel;
  logic [1:0]                  gain_sel;
  logic [2:0]                  chan_en;
  logic                        any_drop;
  logic                        f_ceil;
  logic                        f_lt_m1;
  logic                        f_gt_vin;

  cpg_dto_if dto ();

  cpg_dropout_timer u_dto (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .dto   (dto.tmr)
  );

  // Comparator flags are asynchronous to the clock; only stage two is read
  assign flag_raw = {chan_short, chan_dropout, vout_open, temp_cool, temp_hot,
                     out_short, iin_lt_300ma, iin_le_400ma, vout_lt_vin_m1,
                     vout_gt_vin, ceil_hyst_low, ceil_reached};

  always_ff @(posedge clk) begin
    if (reset) begin
      flag_meta_r <= '0;
      flag_r      <= '0;
    end else if (ce) begin
      flag_meta_r <= flag_raw;
      flag_r      <= flag_meta_r;
    end
  end

  assign f_ceil   = flag_r[cpg_pkg::F_CEIL];
  assign f_lt_m1  = flag_r[cpg_pkg::F_LT_VIN_M1];
  assign f_gt_vin = flag_r[cpg_pkg::F_GT_VIN];
  assign any_drop = |flag_r[cpg_pkg::F_DROP_LO +: cpg_pkg::NUM_CH];

  // Mode decode from the mode control register
  assign mode_sel = mode_control_reg[cpg_pkg::MODE_HI_BIT:cpg_pkg::MODE_LO_BIT];
  assign gain_sel = mode_control_reg[cpg_pkg::GSEL_HI_BIT:cpg_pkg::GSEL_LO_BIT];
  assign is_het   = (mode_sel == cpg_pkg::MODE_HET) &&
                    (gain_sel == cpg_pkg::GSEL_AUTO);
  assign is_auto  = ((mode_sel == cpg_pkg::MODE_AUTO_TORCH) ||
                     (mode_sel == cpg_pkg::MODE_AUTO_FLASH)) &&
                    (gain_sel == cpg_pkg::GSEL_AUTO);
  assign is_flash = mode_control_reg[cpg_pkg::MODE_LO_BIT] && !is_het;
  assign chan_en  = is_flash ?
                    flash_current_reg[cpg_pkg::CHEN_HI_BIT:cpg_pkg::CHEN_LO_BIT] :
                    torch_current_reg[cpg_pkg::CHEN_HI_BIT:cpg_pkg::CHEN_LO_BIT];

  assign mode_wr  = reg_wr && (reg_addr == cpg_pkg::ADDR_MODE_CTRL);
  assign limit_wr = reg_wr && (reg_addr == cpg_pkg::ADDR_OUT_LIMIT);

  // Whole device off for enable pin, thermal trip, standby or open sense pin
  assign active = !enable_n && !therm_off_r && !standby_r &&
                  !flag_r[cpg_pkg::F_VOUT_OPEN];

  // Register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_control_reg  <= cpg_pkg::MODE_CTRL_RST;
      output_limit_reg  <= cpg_pkg::OUT_LIMIT_RST;
      torch_current_reg <= cpg_pkg::TORCH_CUR_RST;
      flash_current_reg <= cpg_pkg::FLASH_CUR_RST;
    end else if (ce && reg_wr) begin
      unique case (reg_addr)
        cpg_pkg::ADDR_MODE_CTRL: mode_control_reg  <= reg_wdata;
        cpg_pkg::ADDR_OUT_LIMIT: output_limit_reg  <= reg_wdata;
        cpg_pkg::ADDR_TORCH_CUR: torch_current_reg <= reg_wdata;
        cpg_pkg::ADDR_FLASH_CUR: flash_current_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Standby follows the last write of a channel-enable field
  always_ff @(posedge clk) begin
    if (reset) begin
      standby_r <= 1'b1;
    end else if (ce && reg_wr &&
                 (reg_addr == cpg_pkg::ADDR_TORCH_CUR ||
                  reg_addr == cpg_pkg::ADDR_FLASH_CUR)) begin
      standby_r <= (reg_wdata[cpg_pkg::CHEN_HI_BIT:cpg_pkg::CHEN_LO_BIT] == 3'h0);
    end
  end

  // Read port: data one cycle after the strobe, zero for unmapped offsets
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (ce) begin
      rdata_r <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          cpg_pkg::ADDR_MODE_CTRL: rdata_r <= mode_control_reg;
          cpg_pkg::ADDR_OUT_LIMIT: rdata_r <= output_limit_reg;
          cpg_pkg::ADDR_TORCH_CUR: rdata_r <= torch_current_reg;
          cpg_pkg::ADDR_FLASH_CUR: rdata_r <= flash_current_reg;
          cpg_pkg::ADDR_STATUS:
            rdata_r <= {flag_r[cpg_pkg::F_VOUT_OPEN], flag_r[cpg_pkg::F_OUT_SHORT],
                        release_r, standby_r, therm_off_r, pump_on, gain_r};
          default: rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // Thermal latch: trips on hot, clears only on cool
  always_ff @(posedge clk) begin
    if (reset) begin
      therm_off_r <= 1'b0;
    end else if (ce) begin
      if (flag_r[cpg_pkg::F_TEMP_HOT])
        therm_off_r <= 1'b1;
      else if (flag_r[cpg_pkg::F_TEMP_COOL])
        therm_off_r <= 1'b0;
    end
  end

  // Gain the current state asks for, before voltage and short overrides
  always_comb begin
    gain_want   = gain_r;
    state_nxt   = state_r;
    release_nxt = release_r;
    unique case (state_r)
      ST_OFF: begin
        gain_want = cpg_pkg::GAIN_OFF;
        if (is_het) begin
          state_nxt   = ST_HET_CHG;
          gain_want   = cpg_pkg::GAIN_1X;
          release_nxt = 1'b1;
        end else if (is_auto) begin
          state_nxt   = ST_AUTO;
          release_nxt = 1'b0;
          gain_want   = f_gt_vin ? cpg_pkg::GAIN_15X : cpg_pkg::GAIN_1X;
        end else begin
          state_nxt   = ST_PROG;
          release_nxt = 1'b1;
          gain_want   = cpg_pkg::cpg_gain_t'(gain_sel);
        end
      end
      ST_AUTO: begin
        if (f_ceil) begin
          state_nxt   = ST_HOLD;
          gain_want   = cpg_pkg::GAIN_OFF;
          release_nxt = 1'b1;
        end else if (gain_r == cpg_pkg::GAIN_1X &&
                     flag_r[cpg_pkg::F_IIN_LE400]) begin
          gain_want = cpg_pkg::GAIN_15X;
        end else if (gain_r == cpg_pkg::GAIN_15X &&
                     flag_r[cpg_pkg::F_IIN_LT300]) begin
          gain_want = cpg_pkg::GAIN_2X;
        end else begin
          gain_want = gain_r;
        end
      end
      ST_PROG: begin
        gain_want = cpg_pkg::cpg_gain_t'(gain_sel);
        if (f_ceil) begin
          state_nxt = ST_HOLD;
          gain_want = cpg_pkg::GAIN_OFF;
        end
      end
      ST_HOLD: begin
        gain_want = cpg_pkg::GAIN_OFF;
        // A raised ceiling restarts at once, without waiting for the drop
        if (flag_r[cpg_pkg::F_HYST_LOW] || limit_wr) begin
          if (is_auto) begin
            state_nxt = ST_AUTO;
            gain_want = f_gt_vin ? cpg_pkg::GAIN_15X : cpg_pkg::GAIN_1X;
          end else begin
            state_nxt = ST_PROG;
            gain_want = cpg_pkg::cpg_gain_t'(gain_sel);
          end
        end
      end
      ST_HET_CHG: begin
        if (f_ceil) begin
          state_nxt = ST_HET_IDLE;
          gain_want = cpg_pkg::GAIN_OFF;
        end
      end
      ST_HET_IDLE: begin
        gain_want = cpg_pkg::GAIN_OFF;
        if (any_drop && !f_ceil && (|drv_en_r)) begin
          state_nxt = ST_HET_PUMP;
          gain_want = (gain_r == cpg_pkg::GAIN_OFF) ? cpg_pkg::GAIN_1X : gain_r;
        end
      end
      ST_HET_PUMP: begin
        if (f_ceil || !any_drop) begin
          state_nxt = ST_HET_IDLE;
          gain_want = cpg_pkg::GAIN_OFF;
        end else if (dto.expired) begin
          gain_want = cpg_pkg::cpg_step_up(gain_r);
        end
      end
      default: begin
        state_nxt = ST_OFF;
        gain_want = cpg_pkg::GAIN_OFF;
      end
    endcase
    if (mode_wr) begin
      state_nxt = ST_OFF;
      gain_want = cpg_pkg::GAIN_OFF;
    end
  end

  // Voltage window and short protection override any gain asked for except off
  always_comb begin
    gain_nxt = cpg_pkg::cpg_clamp_gain(gain_want, f_lt_m1, f_gt_vin);
    if (gain_nxt != cpg_pkg::GAIN_OFF && flag_r[cpg_pkg::F_OUT_SHORT])
      gain_nxt = cpg_pkg::GAIN_1X;
  end

  // Sequencer state and gain; idle HET keeps last gain for the next restart
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r   <= ST_OFF;
      gain_r    <= cpg_pkg::GAIN_OFF;
      release_r <= 1'b0;
    end else if (ce) begin
      if (!active) begin
        state_r   <= ST_OFF;
        gain_r    <= cpg_pkg::GAIN_OFF;
        release_r <= 1'b0;
      end else begin
        state_r   <= state_nxt;
        release_r <= release_nxt;
        if (state_nxt == ST_HET_IDLE && state_r != ST_HET_CHG)
          gain_r <= gain_r;
        else
          gain_r <= gain_nxt;
      end
    end
  end

  // Pump runs only in charging states with a real gain; PROG with gain 00 keeps the pump off but still enables the LED drivers
  always_ff @(posedge clk) begin
    if (reset) begin
      pump_on <= 1'b0;
    end else if (ce) begin
      pump_on <= active && !mode_wr && (gain_nxt != cpg_pkg::GAIN_OFF) &&
                 (state_nxt == ST_AUTO || state_nxt == ST_PROG ||
                  state_nxt == ST_HET_CHG || state_nxt == ST_HET_PUMP);
    end
  end

  // Dropout timer: armed on pump start, re-armed after each gain step
  assign dto.clear = !active || (state_r != ST_HET_PUMP && state_nxt != ST_HET_PUMP);
  assign dto.start = active && state_nxt == ST_HET_PUMP &&
                     (state_r == ST_HET_IDLE || dto.expired);

  // Channel drivers: shorted channels drop out alone
  always_ff @(posedge clk) begin
    if (reset) begin
      drv_en_r <= 3'h0;
    end else if (ce) begin
      drv_en_r <= (active && release_nxt && !mode_wr) ?
                  (chan_en & ~flag_r[cpg_pkg::F_SHORT_LO +: cpg_pkg::NUM_CH]) :
                  3'h0;
    end
  end

  // Outputs to the analog stage
  assign pump_gain       = pump_on ? gain_r : cpg_pkg::GAIN_OFF;
  assign dropout_sel_180 = (gain_r == cpg_pkg::GAIN_15X) ||
                           (gain_r == cpg_pkg::GAIN_2X);
  assign ceiling_code    = is_flash ?
                           output_limit_reg[cpg_pkg::CEIL_HI_BIT:cpg_pkg::CEIL_LO_BIT] :
                           cpg_pkg::CEIL_CODE_4V5;
  assign ilim_600        = flag_r[cpg_pkg::F_OUT_SHORT];
  assign out_disconnect  = flag_r[cpg_pkg::F_VOUT_OPEN];
  assign standby         = standby_r;
  assign therm_off       = therm_off_r;
  assign chan_drv_en     = drv_en_r;
  assign torch_dac       = torch_current_reg[4:1];
  assign flash_dac       = flash_current_reg[2:0];
  assign flash_sel       = is_flash;
  assign reg_rdata       = rdata_r;

endmodule

//--- verification/cpg_host_model.sv
// Host model driving the register port of the sequencer
`timescale 1ns/1ps
module cpg_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [2:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // Idle bus from time zero
  initial begin
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle write strobe, launched just after an edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Flash charge with ceiling code 110 in auto start
  task automatic charge_flash();
    wr(3'h1, 8'hc0);
    wr(3'h0, 8'hc0);
  endtask
  // Forced 1.5x then ceiling code 111 sends power back
  task automatic reverse_flow();
    wr(3'h0, 8'hd0);
    wr(3'h1, 8'he0);
  endtask
  // Stuck pump: shut down by clearing the channel enables
  task automatic shutdown();
    wr(3'h2, 8'h00);
  endtask
endmodule

//--- verification/cpg_top_monitor.sv
// Port-level assertions for the charge pump gain sequencer
`timescale 1ns/1ps
module cpg_top_monitor (
  // Clock and control
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       enable_n,
  input wire logic [2:0] reg_addr,
  input wire logic       reg_wr,
  // Comparator flags
  input wire logic       out_short,
  input wire logic       temp_hot,
  input wire logic       temp_cool,
  input wire logic       vout_open,
  input wire logic [2:0] chan_short,
  // Design outputs
  input wire logic       pump_on,
  input wire logic [1:0] pump_gain,
  input wire logic       dropout_sel_180,
  input wire logic [2:0] ceiling_code,
  input wire logic       flash_sel,
  input wire logic       ilim_600,
  input wire logic       out_disconnect,
  input wire logic       standby,
  input wire logic       therm_off,
  input wire logic [2:0] chan_drv_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Flags need two sync stages, so repetitions leave margin
  chk_pin_disables: assert property (enable_n [*3] |-> !pump_on && chan_drv_en == 3'h0)
    else $error("pump active while disabled");
  chk_mode_write_off: assert property (reg_wr && reg_addr == 3'h0 |=> !pump_on && !chan_drv_en)
    else $error("mode write did not stop pump and drivers");
  chk_dropout_sel: assert property (pump_on |-> dropout_sel_180 == (pump_gain != 2'h1))
    else $error("dropout threshold does not follow gain");
  chk_torch_ceiling: assert property (!flash_sel |-> ceiling_code == 3'h2)
    else $error("torch ceiling code wrong");
  chk_short_limit: assert property (out_short [*3] |-> ilim_600)
    else $error("short without current limit");
  chk_short_gain: assert property (out_short [*5] ##0 pump_on |-> pump_gain == 2'h1)
    else $error("short did not force 1x");
  chk_open_sense: assert property (vout_open [*3] |-> out_disconnect)
    else $error("open sense left output connected");
  chk_hot_off: assert property (temp_hot [*5] |-> therm_off && !pump_on)
    else $error("hot device still running");
  chk_hot_latch: assert property ((!temp_cool) [*4] ##0 therm_off |=> therm_off)
    else $error("thermal latch released without cool flag");
  chk_led_short: assert property (chan_short[1] [*5] |-> !chan_drv_en[1])
    else $error("shorted channel driver still on");
  chk_standby_dark: assert property (standby [*2] |-> chan_drv_en == 3'h0)
    else $error("drivers on in standby");
  // Main scenarios reached
  cov_gain_2x: cover property (pump_on && pump_gain == 2'h3);
  cov_thermal: cover property (therm_off);
  cov_het_step: cover property (pump_on && dropout_sel_180 && !flash_sel);
endmodule

//--- verification/cpg_top_tb_top.sv
// Self-checking bench for the charge pump gain sequencer
`timescale 1ns/1ps
module cpg_top_tb_top;
  logic clk, reset, ce, enable_n, reg_wr, reg_rd, pump_on, dropout_sel_180, ilim_600;
  logic ceil_reached, ceil_hyst_low, vout_gt_vin, vout_lt_vin_m1, iin_le_400ma;
  logic iin_lt_300ma, out_short, temp_hot, temp_cool, vout_open, out_disconnect;
  logic standby, therm_off, flash_sel;
  logic [2:0] reg_addr, chan_dropout, chan_short, ceiling_code, chan_drv_en, flash_dac;
  logic [7:0] reg_wdata, reg_rdata;
  logic [1:0] pump_gain;
  logic [3:0] torch_dac;
  int err_total;
  int checks_done;
  cpg_top i_cpg_top (.clk, .reset, .ce, .enable_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ceil_reached, .ceil_hyst_low, .vout_gt_vin, .vout_lt_vin_m1, .iin_le_400ma,
    .iin_lt_300ma, .out_short, .temp_hot, .temp_cool, .vout_open, .chan_dropout, .chan_short,
    .pump_on, .pump_gain, .dropout_sel_180, .ceiling_code, .ilim_600, .out_disconnect,
    .standby, .therm_off, .chan_drv_en, .torch_dac, .flash_dac, .flash_sel);
  cpg_host_model i_cpg_host_model (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  // Free-running 100 MHz clock
  always #5 clk = ~clk;
  task automatic ck(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // Fixed waits, settle 1 ns after
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // All comparator flags back to quiet at one edge
  task automatic quiet();
    @(posedge clk);
    {ceil_reached, ceil_hyst_low, vout_gt_vin, vout_lt_vin_m1, iin_le_400ma} <= 5'h00;
    {iin_lt_300ma, out_short, temp_hot, temp_cool, vout_open} <= 5'h00;
    {chan_dropout, chan_short} <= 6'h00;
  endtask
  task automatic t_regs();
    logic [7:0] d;
    i_cpg_host_model.wr(3'h4, 8'hff);
    i_cpg_host_model.rd(3'h4, d);
    ck(d, 8'h10, "status not read-only");
    i_cpg_host_model.wr(3'h1, 8'ha0);
    i_cpg_host_model.rd(3'h1, d);
    ck(d, 8'ha0, "limit readback");
    i_cpg_host_model.wr(3'h5, 8'h5a);
    i_cpg_host_model.rd(3'h5, d);
    ck(d, 8'h00, "unmapped read");
    $display("test regs done");
  endtask
  task automatic t_auto();
    @(posedge clk) enable_n <= 1'b0;
    i_cpg_host_model.wr(3'h2, 8'he0);
    i_cpg_host_model.wr(3'h0, 8'h80);
    wt(3);
    ck({pump_on, pump_gain, chan_drv_en}, 8'h28, "auto start 1x, drivers off");
    @(posedge clk) iin_le_400ma <= 1'b1;
    wt(4);
    ck(pump_gain, 8'h02, "no step to 1.5x");
    @(posedge clk) {iin_lt_300ma, vout_gt_vin} <= 2'h3;
    wt(4);
    ck(pump_gain, 8'h03, "no step to 2x");
    wt(200);
    ck({pump_on, pump_gain}, 8'h07, "2x pump timed out");
    @(posedge clk) ceil_reached <= 1'b1;
    wt(4);
    ck({pump_on, chan_drv_en}, 8'h07, "ceiling kept leds dark");
    @(posedge clk) chan_short <= 3'h2;
    wt(5);
    ck(chan_drv_en, 8'h05, "short channel handling");
    i_cpg_host_model.shutdown();
    wt(3);
    ck({standby, chan_drv_en}, 8'h08, "standby entry");
    $display("test auto done");
  endtask
  task automatic t_het();
    quiet();
    i_cpg_host_model.wr(3'h2, 8'he0);
    i_cpg_host_model.wr(3'h0, 8'h40);
    wt(3);
    ck({pump_on, pump_gain}, 8'h05, "het charge");
    @(posedge clk) ceil_reached <= 1'b1;
    wt(4);
    @(posedge clk) ceil_reached <= 1'b0;
    wt(4);
    ck(pump_on, 8'h00, "het restarted without dropout");
    @(posedge clk) chan_dropout <= 3'h1;
    wt(4);
    ck({pump_on, pump_gain, dropout_sel_180}, 8'h0a, "het dropout 1x");
    wt(2680);
    ck({pump_gain, dropout_sel_180}, 8'h05, "dropout step up");
    @(posedge clk) ceil_reached <= 1'b1;
    wt(4);
    ck(pump_on, 8'h00, "het ceiling stop");
    $display("test het done");
  endtask
  task automatic t_prot();
    quiet();
    @(posedge clk) temp_hot <= 1'b1;
    wt(5);
    ck({therm_off, pump_on}, 8'h02, "hot disable");
    @(posedge clk) temp_hot <= 1'b0;
    wt(5);
    ck(therm_off, 8'h01, "thermal released early");
    @(posedge clk) {temp_cool, out_short, vout_open} <= 3'h7;
    wt(5);
    ck({therm_off, ilim_600, out_disconnect}, 8'h03, "cool, short, open");
    $display("test protection done");
  endtask
  task automatic t_rev();
    quiet();
    @(posedge clk) vout_gt_vin <= 1'b1;
    i_cpg_host_model.wr(3'h3, 8'he0);
    i_cpg_host_model.charge_flash();
    wt(3);
    ck({flash_sel, ceiling_code, pump_on, pump_gain}, 8'h76, "flash auto 1.5x");
    @(posedge clk) ceil_reached <= 1'b1;
    wt(4);
    i_cpg_host_model.reverse_flow();
    @(posedge clk) {ceil_reached, ceil_hyst_low} <= 2'h1;
    wt(4);
    ck({ceiling_code, pump_on, pump_gain}, 8'h3e, "reverse flow 1.5x");
    @(posedge clk) enable_n <= 1'b1;
    wt(3);
    ck(pump_on, 8'h00, "pin disable");
    $display("test reverse done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence: reset for five cycles, then the scenarios
  initial begin
    {clk, ce, reset, enable_n} = 4'h7;
    err_total = 0;
    checks_done = 0;
    {ceil_reached, ceil_hyst_low, vout_gt_vin, vout_lt_vin_m1, iin_le_400ma} = 5'h00;
    {iin_lt_300ma, out_short, temp_hot, temp_cool, vout_open} = 5'h00;
    {chan_dropout, chan_short} = 6'h00;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_auto();
    t_het();
    t_prot();
    t_rev();
    end_of_test();
  end
endmodule
bind cpg_top cpg_top_monitor i_cpg_top_monitor (.clk, .reset, .enable_n, .reg_addr, .reg_wr,
  .out_short, .temp_hot, .temp_cool, .vout_open, .chan_short, .pump_on, .pump_gain,
  .dropout_sel_180, .ceiling_code, .flash_sel, .ilim_600, .out_disconnect, .standby,
  .therm_off, .chan_drv_en);
